// file: rtl/sptm_scan_timer.sv
/*
  One non-retentive scan timer with constant or register preset,
  stop-at-preset option, register port and interrupt output.
  Assumes the instruction engine pulses scan_exec once per program scan
  and drives timer_enable as the rung's enable level.
*/
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sptm_scan_timer
  import sptm_pkg::*;
#(
  parameter int unsigned TIMER_INDEX  = 0,
  parameter logic [15:0] PRESET_CONST = 16'h03E8,
  parameter int unsigned FAST_CYCLES  = TB_FAST_CYCLES,
  parameter int unsigned MID_CYCLES   = TB_MID_CYCLES,
  parameter int unsigned SLOW_CYCLES  = TB_SLOW_CYCLES
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // ladder program side
  input  wire logic              timer_enable,
  input  wire logic              scan_exec,
  output logic                   timer_contact,
  output logic                   time_up_flag,
  output logic [CNT_W-1:0]       current_count,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  // interrupt
  output logic                   irq
);

  // elaboration checks: no index beyond the last timer, no preset the count cannot reach
  if (TIMER_INDEX > IDX_LAST)
  begin
    $error("sptm_scan_timer: TIMER_INDEX out of range");
  end
  if (PRESET_CONST > COUNT_LIMIT)
  begin
    $error("sptm_scan_timer: PRESET_CONST above count limit");
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic tick_fast;
  logic tick_mid;
  logic tick_slow;
  logic tb_tick;

  sptm_tick_gen #(.PERIOD(FAST_CYCLES)) u_tb_fast
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_fast)
  );

  sptm_tick_gen #(.PERIOD(MID_CYCLES)) u_tb_mid
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_mid)
  );

  sptm_tick_gen #(.PERIOD(SLOW_CYCLES)) u_tb_slow
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick_slow)
  );

  // index fixes the base at build time; dividers run free so a base is shared
  assign tb_tick = (TIMER_INDEX <= IDX_FAST_LAST) ? tick_fast :
                   (TIMER_INDEX <= IDX_MID_LAST)  ? tick_mid  : tick_slow;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic              stop_at_preset_select;
  logic              preset_from_reg;
  logic [15:0]       preset_reg;
  logic              next_stop;
  logic              next_src;
  logic [15:0]       next_preset_reg;
  logic [15:0]       preset_value;
  logic              wr_ctrl;

  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);

  always_comb
  begin
    next_stop       = stop_at_preset_select;
    next_src        = preset_from_reg;
    next_preset_reg = preset_reg;
    if (wr_ctrl)
    begin
      next_stop = reg_wdata[CTRL_STOP_BIT];
      next_src  = reg_wdata[CTRL_SRC_BIT];
    end
    if (reg_wr && (reg_addr == ADDR_PRESET))
      next_preset_reg = reg_wdata;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stop_at_preset_select <= CTRL_RESET[CTRL_STOP_BIT];
      preset_from_reg       <= CTRL_RESET[CTRL_SRC_BIT];
      preset_reg            <= PRESET_RESET;
    end
    else
    begin
      stop_at_preset_select <= next_stop;
      preset_from_reg       <= next_src;
      preset_reg            <= next_preset_reg;
    end
  end

  // register preset is read live, so a rewrite while running takes effect at once
  assign preset_value = preset_from_reg ? preset_reg : PRESET_CONST;

  // ----------------------------------------------------------------
  // count and time-up
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] next_count;
  logic             next_contact;
  logic             next_time_up;
  logic             reached;

  assign reached = (current_count >= preset_value);

  always_comb
  begin
    next_count   = current_count;
    next_contact = timer_contact;
    next_time_up = time_up_flag;
    if (!timer_enable)
    begin
      next_count   = COUNT_RESET;
      next_contact = 1'b0;
      next_time_up = 1'b0;
    end
    else
    begin
      if (tb_tick)
      begin
        if (stop_at_preset_select && reached)
          next_count = preset_value;
        else if (current_count < COUNT_LIMIT)
          next_count = current_count + 16'h0001;
      end
      // contact and time-up outputs follow the program scan, as the ladder sees them
      if (scan_exec)
      begin
        next_contact = reached;
        next_time_up = reached;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      current_count <= COUNT_RESET;
      timer_contact <= 1'b0;
      time_up_flag  <= 1'b0;
    end
    else
    begin
      current_count <= next_count;
      timer_contact <= next_contact;
      time_up_flag  <= next_time_up;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  sptm_irq_if irq_bus ();

  // one process drives the whole event vector, so each bit has a single driver
  always_comb
  begin
    irq_bus.event_set               = {EVT_W{1'b0}};
    irq_bus.event_set[EVT_TIME_UP]  = next_time_up && !time_up_flag;
    irq_bus.event_set[EVT_SATURATE] = (next_count == COUNT_LIMIT) && (current_count != COUNT_LIMIT);
  end

  assign irq_bus.wdata                   = reg_wdata[EVT_W-1:0];
  assign irq_bus.clr_we                  = reg_wr && (reg_addr == ADDR_IRQ_STAT);
  assign irq_bus.mask_we                 = reg_wr && (reg_addr == ADDR_IRQ_MASK);

  sptm_irq_regs u_irq
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .irq_bus  (irq_bus),
    .irq      (irq)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  // unmapped addresses read as zero; data stand for one cycle only
  always_comb
  begin
    next_rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL:
        begin
          next_rdata[CTRL_STOP_BIT] = stop_at_preset_select;
          next_rdata[CTRL_SRC_BIT]  = preset_from_reg;
        end
        ADDR_PRESET:
          next_rdata = preset_reg;
        ADDR_COUNT:
          next_rdata = current_count;
        ADDR_FLAGS:
        begin
          next_rdata[FLAG_CONTACT] = timer_contact;
          next_rdata[FLAG_TIME_UP] = time_up_flag;
          next_rdata[FLAG_ENABLE]  = timer_enable;
        end
        ADDR_IRQ_STAT:
          next_rdata[EVT_W-1:0] = irq_bus.status;
        ADDR_IRQ_MASK:
          next_rdata[EVT_W-1:0] = irq_bus.mask;
        default:
          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  en_clear_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !timer_enable |=> (current_count == 16'h0000) && !timer_contact && !time_up_flag)
    else $error("disable did not clear timer");

  time_up_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (timer_enable && scan_exec && reached) |=> (timer_contact && time_up_flag))
    else $error("time-up not flagged on scan");

  count_step_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (timer_enable && tb_tick && !stop_at_preset_select && current_count < COUNT_LIMIT)
      |=> current_count == $past(current_count) + 16'h0001)
    else $error("count did not advance by one");

  no_tick_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (timer_enable && !tb_tick) |=> $stable(current_count))
    else $error("count moved without a tick");

  saturate_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (timer_enable && !stop_at_preset_select && current_count == COUNT_LIMIT)
      |=> current_count == COUNT_LIMIT)
    else $error("count left its limit");

  hold_preset_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (timer_enable && stop_at_preset_select && tb_tick && reached)
      |=> current_count == $past(preset_value))
    else $error("count not held at preset");

  zero_preset_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (timer_enable && scan_exec && preset_value == 16'h0000) ##1 timer_enable [*2]
      |-> timer_contact && time_up_flag)
    else $error("zero preset not flagged after scan");

  reg_preset_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (timer_enable && scan_exec && preset_from_reg && current_count < preset_reg)
      |=> !timer_contact)
    else $error("register preset not honoured");

  stop_write_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $changed(stop_at_preset_select) |-> $past(wr_ctrl))
    else $error("stop option changed without write");

endmodule
`default_nettype wire

// file: rtl/sptm_pkg.sv
/*
  Shared constants of the scan timer: clock rate, time-base periods,
  timer index ranges, count limit, register map and field positions.
  Assumes a single 20 MHz core clock and a 16-bit register port.
*/
package sptm_pkg;

  // ----------------------------------------------------------------
  // clock and time bases
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CYCLES_PER_MS  = CLK_HZ / 1000;
  localparam int unsigned TB_FAST_MS     = 10;
  localparam int unsigned TB_MID_MS      = 100;
  localparam int unsigned TB_SLOW_MS     = 1000;
  localparam int unsigned TB_FAST_CYCLES = CYCLES_PER_MS * TB_FAST_MS;
  localparam int unsigned TB_MID_CYCLES  = CYCLES_PER_MS * TB_MID_MS;
  localparam int unsigned TB_SLOW_CYCLES = CYCLES_PER_MS * TB_SLOW_MS;

  // ----------------------------------------------------------------
  // timer index ranges that pick the time base
  // ----------------------------------------------------------------
  localparam int unsigned IDX_FAST_LAST  = 511;
  localparam int unsigned IDX_MID_LAST   = 767;
  localparam int unsigned IDX_LAST       = 1023;

  // ----------------------------------------------------------------
  // count
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W          = 16;
  localparam logic [15:0] COUNT_LIMIT    = 16'h7FFF;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 16;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_PRESET    = 8'h04;
  localparam logic [7:0]  ADDR_COUNT     = 8'h08;
  localparam logic [7:0]  ADDR_FLAGS     = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h14;
  localparam int unsigned CTRL_STOP_BIT  = 0;
  localparam int unsigned CTRL_SRC_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [15:0] PRESET_RESET   = 16'h0000;
  localparam int unsigned FLAG_CONTACT   = 0;
  localparam int unsigned FLAG_TIME_UP   = 1;
  localparam int unsigned FLAG_ENABLE    = 2;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int unsigned EVT_TIME_UP    = 0;
  localparam int unsigned EVT_SATURATE   = 1;
  localparam int unsigned EVT_W          = 2;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

endpackage

// file: rtl/sptm_irq_if.sv
/*
  Carrier between the timer core and its interrupt register block.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface sptm_irq_if;
  import sptm_pkg::*;
  logic [EVT_W-1:0] event_set;
  logic [EVT_W-1:0] wdata;
  logic             clr_we;
  logic             mask_we;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;

  modport core (output event_set, output wdata, output clr_we, output mask_we,
                input status, input mask);
  modport regs (input event_set, input wdata, input clr_we, input mask_we,
                output status, output mask);
endinterface
`default_nettype wire

// file: rtl/sptm_tick_gen.sv
/*
  Free-running divider giving a one-cycle tick every PERIOD cycles.
  Assumes the core clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sptm_tick_gen
  import sptm_pkg::*;
#(
  parameter int unsigned PERIOD = TB_FAST_CYCLES
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // tick
  output logic      tick
);

  // refused at elaboration: a period of one would leave tick stuck high
  if (PERIOD < 2)
  begin
    $error("sptm_tick_gen: PERIOD must be at least 2");
  end

  logic [31:0] div_cnt;
  logic [31:0] next_div_cnt;
  logic        next_tick;

  always_comb
  begin
    next_tick    = (div_cnt == 32'(PERIOD - 1));
    next_div_cnt = next_tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

endmodule
`default_nettype wire

// file: rtl/sptm_irq_regs.sv
/*
  Sticky interrupt status with write-one-to-clear, mask and one level irq.
  Assumes the core drives one-cycle event pulses and write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module sptm_irq_regs
  import sptm_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // core side
  sptm_irq_if.regs  irq_bus,
  // interrupt
  output logic      irq
);

  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] next_mask;
  logic             next_irq;

  // a new event beats a clear in the same cycle
  always_comb
  begin
    next_status = status;
    if (irq_bus.clr_we)
      next_status = next_status & ~irq_bus.wdata;
    next_status = next_status | irq_bus.event_set;
    next_mask   = irq_bus.mask_we ? irq_bus.wdata : mask;
    next_irq    = |(next_status & next_mask);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status <= IRQ_RESET;
      mask   <= IRQ_RESET;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= next_irq;
    end
  end

  assign irq_bus.status = status;
  assign irq_bus.mask   = mask;

endmodule
`default_nettype wire

// file: verification/test_sptm_scan_timer.sv
/*
  Self-checking bench for the scan timer: register port, preset modes,
  stop option, saturation and interrupt masking, driven by call sequences.
  Assumes the timer core with a shortened fast time base and a const preset of 2.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sptm_scan_timer;
  import sptm_pkg::*;

  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  // two-cycle tick keeps the full climb to the limit under 70k cycles
  localparam int unsigned TB_CYC = 2;
  // slower bases differ so a wrong base pick shows in the count rate
  localparam int unsigned TB_MID_CYC  = 4;
  localparam int unsigned TB_SLOW_CYC = 8;
  localparam int unsigned WAIT_MAX = 70000;

  logic              core_clk;
  logic              resetn;
  logic              timer_enable;
  logic              scan_exec;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic              timer_contact;
  logic              time_up_flag;
  logic [CNT_W-1:0]  current_count;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq;
  logic [15:0]       snap;
  int                bad_count;
  int                compares;

  sptm_scan_timer #(
    .TIMER_INDEX  (0),
    .PRESET_CONST (16'h0002),
    .FAST_CYCLES  (TB_CYC),
    .MID_CYCLES   (TB_MID_CYC),
    .SLOW_CYCLES  (TB_SLOW_CYC)
  ) uut (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .timer_enable  (timer_enable),
    .scan_exec     (scan_exec),
    .timer_contact (timer_contact),
    .time_up_flag  (time_up_flag),
    .current_count (current_count),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .irq           (irq)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  // settle one step past the edge so registered outputs have landed
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk_val(reg_rdata, exp);
  endtask

  task automatic scan(input logic c, input logic f);
    @(posedge core_clk);
    scan_exec <= 1'b1;
    @(posedge core_clk);
    scan_exec <= 1'b0;
    #1;
    chk_bit(timer_contact, c);
    chk_bit(time_up_flag, f);
  endtask

  task automatic set_en(input logic v);
    @(posedge core_clk);
    timer_enable <= v;
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    while (current_count !== v && n < WAIT_MAX)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_val(current_count, v);
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    // tests need about 66k cycles, mostly the climb to the limit
    repeat (90000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    bad_count    = 0;
    compares     = 0;
    resetn       = 1'b0;
    timer_enable = 1'b0;
    scan_exec    = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    idle(1);
    chk_val(current_count, COUNT_RESET);
    chk_bit(irq, 1'b0);
    rd(ADDR_CTRL, {14'h0000, CTRL_RESET});
    rd(ADDR_PRESET, PRESET_RESET);
    rd(ADDR_IRQ_STAT, 16'h0000);
    rd(ADDR_IRQ_MASK, 16'h0000);
    // unmapped and read-only places swallow writes
    wr(8'h20, 16'hFFFF);
    wr(ADDR_COUNT, 16'h0055);
    rd(8'h20, 16'h0000);
    rd(ADDR_COUNT, 16'h0000);
    rd(ADDR_CTRL, 16'h0000);

    // constant preset, keep counting past it
    set_en(1'b1);
    scan(1'b0, 1'b0);
    wait_cnt(16'h0002);
    scan(1'b1, 1'b1);
    rd(ADDR_FLAGS, 16'h0007);
    chk_bit(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 16'h0001);
    idle(1);
    chk_bit(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 16'h0001);
    idle(1);
    chk_bit(irq, 1'b0);
    rd(ADDR_IRQ_STAT, 16'h0000);
    snap = current_count;
    idle(8);
    chk_val(current_count, snap + 16'h0004);
    scan(1'b1, 1'b1);
    set_en(1'b0);
    idle(1);
    chk_val(current_count, 16'h0000);
    chk_bit(timer_contact, 1'b0);
    chk_bit(time_up_flag, 1'b0);

    // stop option holds the count at the preset
    wr(ADDR_CTRL, 16'h0001);
    set_en(1'b1);
    wait_cnt(16'h0002);
    idle(10);
    chk_val(current_count, 16'h0002);
    scan(1'b1, 1'b1);
    set_en(1'b0);
    idle(1);

    // register preset, altered while running
    wr(ADDR_CTRL, 16'h0002);
    wr(ADDR_PRESET, 16'h0005);
    set_en(1'b1);
    wait_cnt(16'h0004);
    scan(1'b0, 1'b0);
    wait_cnt(16'h0005);
    scan(1'b1, 1'b1);
    wr(ADDR_PRESET, 16'h0064);
    scan(1'b0, 1'b0);
    wait_cnt(16'h0064);
    scan(1'b1, 1'b1);
    set_en(1'b0);
    idle(1);

    // zero preset is up after the first scan
    wr(ADDR_PRESET, 16'h0000);
    set_en(1'b1);
    scan(1'b1, 1'b1);
    idle(20);
    chk_bit(timer_contact, 1'b1);
    set_en(1'b0);
    idle(1);
    chk_bit(timer_contact, 1'b0);
    chk_bit(time_up_flag, 1'b0);

    // climb to the limit; only the masked-in event drives irq
    wr(ADDR_IRQ_STAT, 16'h0003);
    wr(ADDR_CTRL, 16'h0000);
    set_en(1'b1);
    wait_cnt(COUNT_LIMIT);
    idle(8);
    chk_val(current_count, COUNT_LIMIT);
    scan(1'b1, 1'b1);
    rd(ADDR_IRQ_STAT, 16'h0003);
    wr(ADDR_IRQ_MASK, 16'h0002);
    idle(1);
    chk_bit(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 16'h0002);
    idle(1);
    chk_bit(irq, 1'b0);
    rd(ADDR_IRQ_STAT, 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
